// *** logic/exception_vector_dispatch.sv ***
`timescale 1ns/1ps
module exception_vector_dispatch
  import exc_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Core event inputs, one-cycle strobes.
  input wire logic faultStrobe,
  input wire cause_type faultCause,
  input wire logic [3:0] trapNumber,
  input wire logic [15:0] opcode,
  input wire logic opcodeValid,
  input wire logic accessStrobe,
  input wire logic [23:0] accessAddr,
  input wire logic accessWide,
  input wire logic accessSuper,
  input wire logic userMode,
  input wire logic instrDone,
  input wire logic traceBit,
  input wire logic resetInstr,
  // Results to the core.
  output logic dispatchBusy,
  output logic newPcValid,
  output logic [31:0] newPc,
  output logic [7:0] lastVector,
  // Link to memory and interrupt logic.
  exc_link_if.cpu link
);
  typedef enum logic [5:0] {
    ST_BOOT = 6'b000001, ST_IDLE = 6'b000010, ST_IACK = 6'b000100,
    ST_FETCH = 6'b001000, ST_DONE = 6'b010000, ST_HALT = 6'b100000
  } state_type;

  state_type state_reg;
  logic [7:0] vector_reg;
  logic [31:0] newPc_reg;
  logic newPcValid_reg;
  logic [7:0] pulse_reg;
  logic [2:0] irqSync1_reg, irqSync2_reg, irqSync3_reg, irqLevel_reg;
  logic pendVector;
  logic [7:0] pendVectorNum;
  logic irqPending;

  // Legal vectors avoid the unassigned band so a stray cause can never reach it.
  function automatic logic [7:0] legal_vector(input logic [7:0] v);
    if (v >= VEC_UNASSIGNED_FIRST && v <= VEC_UNASSIGNED_LAST) begin
      legal_vector = VEC_ILLEGAL;
    end else begin
      legal_vector = v;
    end
  endfunction

  // Table location of a vector is four times its number.
  function automatic logic [23:0] table_addr(input logic [7:0] v);
    table_addr = {14'h0000, v, 2'b00};
  endfunction

  // Interrupt level arrives from outside logic and passes three flops, then a register loaded only when the last two agree.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqSync1_reg <= 3'h0;
      irqSync2_reg <= 3'h0;
      irqSync3_reg <= 3'h0;
      irqLevel_reg <= 3'h0;
    end else begin
      irqSync1_reg <= link.irqLevel;
      irqSync2_reg <= irqSync1_reg;
      irqSync3_reg <= irqSync2_reg;
      if (irqSync2_reg == irqSync3_reg) begin
        irqLevel_reg <= irqSync3_reg;
      end
    end
  end
  assign irqPending = irqLevel_reg != 3'h0;

  // Classify the highest-priority event this cycle into a vector number.
  always_comb begin
    pendVector = 1'b0;
    pendVectorNum = VEC_ILLEGAL;
    if (link.busErr && state_reg == ST_IDLE) begin
      pendVector = 1'b1;
      pendVectorNum = VEC_BUS_ERR;
    end else if (accessStrobe && accessWide && accessAddr[0]) begin
      pendVector = 1'b1;
      pendVectorNum = VEC_ADDR_ERR;
    end else if (accessStrobe && accessSuper && userMode) begin
      pendVector = 1'b1;
      pendVectorNum = VEC_PRIV;
    end else if (opcodeValid && opcode[15:12] == OPLINE_A) begin
      pendVector = 1'b1;
      pendVectorNum = VEC_EMU_A;
    end else if (opcodeValid && opcode[15:12] == OPLINE_F) begin
      pendVector = 1'b1;
      pendVectorNum = VEC_EMU_F;
    end else if (faultStrobe) begin
      pendVector = 1'b1;
      case (faultCause)
        CAUSE_BUS: pendVectorNum = VEC_BUS_ERR;
        CAUSE_ADDR: pendVectorNum = VEC_ADDR_ERR;
        CAUSE_ILLEGAL: pendVectorNum = VEC_ILLEGAL;
        CAUSE_ZDIV: pendVectorNum = VEC_ZERO_DIV;
        CAUSE_BOUNDS: pendVectorNum = VEC_BOUNDS;
        CAUSE_OVF: pendVectorNum = VEC_OVF_TRAP;
        CAUSE_PRIV: pendVectorNum = VEC_PRIV;
        CAUSE_TRACE: pendVectorNum = VEC_TRACE;
        CAUSE_TRAP: pendVectorNum = VEC_TRAP_BASE + {4'h0, trapNumber};
        default: pendVectorNum = VEC_ILLEGAL;
      endcase
    end else if (instrDone && traceBit) begin
      pendVector = 1'b1;
      pendVectorNum = VEC_TRACE;
    end
  end

  // Dispatch sequencer: boot fetch, acknowledge, handler fetch.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_BOOT;
      vector_reg <= VEC_RESET_PC;
    end else begin
      case (state_reg)
        ST_BOOT: begin
          if (link.memAck) begin
            state_reg <= link.busErr ? ST_HALT : ST_DONE;
          end
        end
        ST_IDLE: begin
          if (pendVector) begin
            vector_reg <= legal_vector(pendVectorNum);
            state_reg <= ST_FETCH;
          end else if (irqPending) begin
            state_reg <= ST_IACK;
          end
        end
        ST_IACK: begin
          if (link.busErr) begin
            vector_reg <= VEC_SPURIOUS;
            state_reg <= ST_FETCH;
          end else if (link.iackAck) begin
            if (link.iackAuto) begin
              vector_reg <= VEC_AUTO_BASE + {5'h00, irqLevel_reg};
            end else begin
              vector_reg <= legal_vector(link.iackVector);
            end
            state_reg <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          // A fault during the handler fetch is fatal, as a double fault.
          if (link.busErr) begin
            state_reg <= ST_HALT;
          end else if (link.memAck) begin
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: state_reg <= ST_IDLE;
        ST_HALT: state_reg <= ST_HALT;
        default: state_reg <= ST_HALT;
      endcase
    end
  end

  // Handler address capture and one-cycle jump strobe.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      newPc_reg <= 32'h00000000;
      newPcValid_reg <= 1'b0;
    end else begin
      newPcValid_reg <= 1'b0;
      if ((state_reg == ST_FETCH || state_reg == ST_BOOT) && link.memAck && !link.busErr) begin
        newPc_reg <= link.memData;
        newPcValid_reg <= 1'b1;
      end
    end
  end

  // Outward reset pulse; the core state above is left alone.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_reg <= 8'h00;
    end else if (resetInstr && state_reg == ST_IDLE) begin
      pulse_reg <= RESET_PULSE_CYCLES;
    end else if (pulse_reg != 8'h00) begin
      pulse_reg <= pulse_reg - 8'h01;
    end
  end

  assign link.memReq = state_reg == ST_BOOT || state_reg == ST_FETCH;
  assign link.memAddr = state_reg == ST_BOOT ? RESET_PC_ADDR : table_addr(vector_reg);
  assign link.iackReq = state_reg == ST_IACK;
  assign link.sysReset = pulse_reg != 8'h00;
  assign dispatchBusy = state_reg != ST_IDLE;
  assign newPc = newPc_reg;
  assign newPcValid = newPcValid_reg;
  assign lastVector = vector_reg;
endmodule

// *** logic/exc_pkg.sv ***
package exc_pkg;
  // Fixed exception vector numbers.
  localparam logic [7:0] VEC_RESET_PC = 8'h01;
  localparam logic [7:0] VEC_BUS_ERR = 8'h02;
  localparam logic [7:0] VEC_ADDR_ERR = 8'h03;
  localparam logic [7:0] VEC_ILLEGAL = 8'h04;
  localparam logic [7:0] VEC_ZERO_DIV = 8'h05;
  localparam logic [7:0] VEC_BOUNDS = 8'h06;
  localparam logic [7:0] VEC_OVF_TRAP = 8'h07;
  localparam logic [7:0] VEC_PRIV = 8'h08;
  localparam logic [7:0] VEC_TRACE = 8'h09;
  localparam logic [7:0] VEC_EMU_A = 8'h0A;
  localparam logic [7:0] VEC_EMU_F = 8'h0B;
  // Band of vector numbers that must never be dispatched.
  localparam logic [7:0] VEC_UNASSIGNED_FIRST = 8'h0C;
  localparam logic [7:0] VEC_UNASSIGNED_LAST = 8'h17;
  localparam logic [7:0] VEC_SPURIOUS = 8'h18;
  localparam logic [7:0] VEC_AUTO_BASE = 8'h18;
  localparam logic [7:0] VEC_TRAP_BASE = 8'h20;
  localparam logic [7:0] VEC_PERIPH_FIRST = 8'h40;
  localparam logic [7:0] VEC_PERIPH_LAST = 8'h4F;
  localparam logic [7:0] VEC_USER_FIRST = 8'h50;
  // Opcode line patterns for emulation traps.
  localparam logic [3:0] OPLINE_A = 4'hA;
  localparam logic [3:0] OPLINE_F = 4'hF;
  // Boot overlay: low window 0-7 shows ROM at E00000-7.
  localparam logic [23:0] BOOT_ROM_BASE = 24'hE00000;
  localparam logic [23:0] OVERLAY_MASK = 24'hFFFFF8;
  localparam logic [23:0] RESET_PC_ADDR = 24'h000004;
  // Length of the outward reset pulse in processor cycles.
  localparam logic [7:0] RESET_PULSE_CYCLES = 8'h7C;
  // Fault cause codes presented with a fault strobe.
  typedef enum logic [3:0] {
    CAUSE_BUS = 4'h0, CAUSE_ADDR = 4'h1, CAUSE_ILLEGAL = 4'h2, CAUSE_ZDIV = 4'h3,
    CAUSE_BOUNDS = 4'h4, CAUSE_OVF = 4'h5, CAUSE_PRIV = 4'h6, CAUSE_TRACE = 4'h7,
    CAUSE_TRAP = 4'h8
  } cause_type;
endpackage

// *** logic/exc_link_if.sv ***
`timescale 1ns/1ps
// Memory port plus interrupt and bus-error signalling between the two ends.
interface exc_link_if;
  logic memReq;
  logic [23:0] memAddr;
  logic [31:0] memData;
  logic memAck;
  logic busErr;
  logic [2:0] irqLevel;
  logic iackReq;
  logic [7:0] iackVector;
  logic iackAuto;
  logic iackAck;
  logic sysReset;
  modport cpu (output memReq, memAddr, iackReq, sysReset,
               input memData, memAck, busErr, irqLevel, iackVector, iackAuto, iackAck);
  modport sys (input memReq, memAddr, iackReq, sysReset,
               output memData, memAck, busErr, irqLevel, iackVector, iackAuto, iackAck);
endinterface

// *** logic/exception_system_end.sv ***
`timescale 1ns/1ps
// Memory controller and interrupt side of the exception link.
module exception_system_end
  import exc_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Memory array port, one-cycle read answer.
  output logic [23:0] romAddr,
  input wire logic [31:0] romData,
  input wire logic memFault,
  // Interrupt sources.
  input wire logic [2:0] irqLevelIn,
  input wire logic periphActive,
  input wire logic [3:0] periphChannel,
  input wire logic [7:0] userVector,
  input wire logic autoVectorMode,
  input wire logic iackFault,
  // Link to the processor.
  exc_link_if.sys link
);
  logic ack_reg;
  logic [31:0] data_reg;
  logic iackAck_reg;
  logic [7:0] iackVector_reg;
  logic busErr_reg;

  // Low eight bytes map onto boot ROM so reset vectors come from ROM.
  always_comb begin
    if ((link.memAddr & OVERLAY_MASK) == 24'h000000) begin
      romAddr = BOOT_ROM_BASE | link.memAddr;
    end else begin
      romAddr = link.memAddr;
    end
  end

  // Read answers one cycle after the request; a fault answers as bus error.
  // The bus error is a single-cycle pulse: held longer it would look like a second
  // fault on the fetch that follows a failed acknowledge and halt the processor.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      data_reg <= 32'h00000000;
      busErr_reg <= 1'b0;
    end else begin
      ack_reg <= link.memReq && !ack_reg;
      data_reg <= romData;
      busErr_reg <= !busErr_reg && ((link.memReq && !ack_reg && memFault) ||
                    (link.iackReq && !iackAck_reg && iackFault));
    end
  end

  // Interrupt acknowledge answer: peripheral channel or user vector.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      iackAck_reg <= 1'b0;
      iackVector_reg <= 8'h00;
    end else begin
      iackAck_reg <= link.iackReq && !iackAck_reg && !iackFault;
      if (periphActive) begin
        iackVector_reg <= VEC_PERIPH_FIRST + {4'h0, periphChannel};
      end else if (userVector < VEC_USER_FIRST) begin
        iackVector_reg <= VEC_USER_FIRST;
      end else begin
        iackVector_reg <= userVector;
      end
    end
  end

  assign link.memAck = ack_reg;
  assign link.memData = data_reg;
  assign link.busErr = busErr_reg;
  assign link.irqLevel = irqLevelIn;
  assign link.iackAck = iackAck_reg;
  assign link.iackVector = iackVector_reg;
  // Only even autovector levels are expected in this system.
  assign link.iackAuto = autoVectorMode && !periphActive;
endmodule

// *** test/exception_vector_dispatch_chk.sv ***
`timescale 1ns/1ps
// Watches the exception link between the processor end and the system end.
module exception_vector_dispatch_chk
  import exc_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst_n,
  // Link signals.
  input wire logic memReq,
  input wire logic [23:0] memAddr,
  input wire logic memAck,
  input wire logic busErr,
  input wire logic iackReq,
  input wire logic [7:0] iackVector,
  input wire logic iackAuto,
  input wire logic iackAck,
  input wire logic sysReset
);
  logic [7:0] resetCount;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Counts the outward reset length so it can be checked exactly, not just bounded.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      resetCount <= 8'h00;
    end else if (sysReset) begin
      resetCount <= resetCount + 8'h01;
    end else begin
      resetCount <= 8'h00;
    end
  end
  chk_req_held: assert property (
    memReq && !memAck && !busErr |=> memReq && $stable(memAddr))
    else $error("memory request dropped or moved before its answer");
  chk_ack_latency: assert property (
    $rose(memReq) |=> memAck || busErr)
    else $error("memory answer late");
  chk_ack_pulse: assert property (
    memAck |=> !memAck)
    else $error("memory answer longer than one cycle");
  chk_fetch_aligned: assert property (
    memReq |-> memAddr[1:0] == 2'h0)
    else $error("vector fetch not longword aligned");
  chk_no_unassigned: assert property (
    memReq |-> !(memAddr >= 24'h000030 && memAddr <= 24'h00005C))
    else $error("unassigned vector fetched");
  chk_iack_answer: assert property (
    $rose(iackReq) |-> ##[1:8] (iackAck || busErr))
    else $error("acknowledge cycle not answered");
  chk_iack_vec: assert property (
    iackAck && !iackAuto && !busErr |-> iackVector >= VEC_PERIPH_FIRST)
    else $error("supplied vector below peripheral range");
  chk_pulse_len: assert property (
    $fell(sysReset) |-> resetCount == RESET_PULSE_CYCLES)
    else $error("outward reset pulse has wrong length");
endmodule

// *** test/exception_vector_dispatch_bench.sv ***
`timescale 1ns/1ps
// Drives both user sides of the link and checks every dispatch against the vector map.
module exception_vector_dispatch_bench
  import exc_pkg::*;
  ();
  logic ref_clk, rst_n, faultStrobe, opcodeValid, accessStrobe, accessWide, accessSuper;
  logic userMode, instrDone, traceBit, resetInstr, dispatchBusy, newPcValid;
  logic periphActive, autoVectorMode, iackFault, memFault;
  cause_type faultCause;
  logic [3:0] trapNumber, periphChannel, t;
  logic [15:0] opcode;
  logic [23:0] accessAddr, romAddr;
  logic [31:0] newPc, romData;
  logic [7:0] lastVector, userVector, pulseLen;
  logic [2:0] irqLevelIn;
  int miscompares, checked, k, c;
  exc_link_if link();
  exception_vector_dispatch i_exception_vector_dispatch (.ref_clk(ref_clk), .rst_n(rst_n),
    .faultStrobe(faultStrobe), .faultCause(faultCause), .trapNumber(trapNumber),
    .opcode(opcode), .opcodeValid(opcodeValid), .accessStrobe(accessStrobe),
    .accessAddr(accessAddr), .accessWide(accessWide), .accessSuper(accessSuper),
    .userMode(userMode), .instrDone(instrDone), .traceBit(traceBit), .resetInstr(resetInstr),
    .dispatchBusy(dispatchBusy), .newPcValid(newPcValid), .newPc(newPc),
    .lastVector(lastVector), .link(link));
  exception_system_end i_exception_system_end (.ref_clk(ref_clk), .rst_n(rst_n),
    .romAddr(romAddr), .romData(romData), .memFault(memFault), .irqLevelIn(irqLevelIn),
    .periphActive(periphActive), .periphChannel(periphChannel), .userVector(userVector),
    .autoVectorMode(autoVectorMode), .iackFault(iackFault), .link(link));
  exception_vector_dispatch_chk chk (.ref_clk(ref_clk), .rst_n(rst_n), .memReq(link.memReq),
    .memAddr(link.memAddr), .memAck(link.memAck), .busErr(link.busErr),
    .iackReq(link.iackReq), .iackVector(link.iackVector), .iackAuto(link.iackAuto),
    .iackAck(link.iackAck), .sysReset(link.sysReset));
  // Memory content is a fixed scramble of the address, so each handler is unique.
  function automatic logic [31:0] hpc(input logic [23:0] a);
    return {~a, 8'hC3};
  endfunction
  function automatic logic [7:0] expVec(input int c, input logic [3:0] tn);
    return (c < 8) ? 8'(c + 2) : VEC_TRAP_BASE + {4'h0, tn};
  endfunction
  assign romData = hpc(romAddr);
  task automatic cmpPc(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmpVec(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Ends the strobes one cycle after launch and drops the irq once the acknowledge request shows.
  task automatic await(input logic [7:0] vec, input logic [31:0] pc);
    @(posedge ref_clk);
    faultStrobe <= 1'b0;
    opcodeValid <= 1'b0;
    accessStrobe <= 1'b0;
    instrDone <= 1'b0;
    traceBit <= 1'b0;
    for (int n = 0; n < 60; n++) begin
      @(posedge ref_clk);
      #1;
      if (link.iackReq === 1'b1) irqLevelIn <= 3'h0;
      if (newPcValid === 1'b1) break;
    end
    cmpVec("newPcValid", 8'h01, {7'h00, newPcValid});
    cmpPc("newPc", pc, newPc);
    cmpVec("lastVector", vec, lastVector);
    cmpVec("dispatchBusy", 8'h01, {7'h00, dispatchBusy});
    repeat (8) @(posedge ref_clk);
    cmpVec("dispatchBusy", 8'h00, {7'h00, dispatchBusy});
  endtask
  task automatic hit(input logic [7:0] vec);
    await(vec, hpc({14'h0000, vec, 2'h0}));
  endtask
  task automatic irq(input logic [2:0] lv, input logic au, input logic pa,
                     input logic [3:0] ch, input logic [7:0] uv, input logic f,
                     input logic [7:0] vec);
    irqLevelIn <= lv;
    autoVectorMode <= au;
    periphActive <= pa;
    periphChannel <= ch;
    userVector <= uv;
    iackFault <= f;
    hit(vec);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Cuts a hang short well past the fewer than one thousand cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    close_out();
  end
  initial begin
    {rst_n, faultStrobe, opcodeValid, accessStrobe, accessWide, accessSuper} = '0;
    {userMode, instrDone, traceBit, resetInstr, periphActive, autoVectorMode} = '0;
    {iackFault, memFault, trapNumber, periphChannel, opcode, accessAddr} = '0;
    {userVector, irqLevelIn} = '0;
    faultCause = CAUSE_BUS;
    void'($urandom(43150));
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    await(VEC_RESET_PC, hpc(BOOT_ROM_BASE + RESET_PC_ADDR));
    for (k = 0; k < 30; k++) begin
      t = 4'($urandom);
      faultStrobe <= 1'b1;
      c = (k < 9) ? k : int'($urandom % 9);
      faultCause <= cause_type'(c);
      trapNumber <= t;
      hit(expVec(c, t));
    end
    for (k = 0; k < 6; k++) begin
      opcode <= {(k % 2) ? OPLINE_F : OPLINE_A, 12'($urandom)};
      opcodeValid <= 1'b1;
      hit((k % 2) ? VEC_EMU_F : VEC_EMU_A);
    end
    for (k = 0; k < 2; k++) begin
      accessAddr <= {23'($urandom), k == 0};
      {accessWide, accessStrobe, accessSuper, userMode} <= {3'h7, k == 1};
      hit(k == 0 ? VEC_ADDR_ERR : VEC_PRIV);
    end
    userMode <= 1'b0;
    traceBit <= 1'b1;
    instrDone <= 1'b1;
    hit(VEC_TRACE);
    for (k = 1; k < 4; k++) irq(3'(2 * k), 1'b1, 1'b0, 4'h0, 8'h00, 1'b0, 8'(24 + 2 * k));
    t = 4'($urandom);
    irq(3'h5, 1'b0, 1'b1, t, 8'h00, 1'b0, VEC_PERIPH_FIRST + {4'h0, t});
    k = 80 + $urandom % 176;
    irq(3'h3, 1'b0, 1'b0, 4'h0, 8'(k), 1'b0, 8'(k));
    irq(3'h3, 1'b0, 1'b0, 4'h0, 8'h10, 1'b0, VEC_USER_FIRST);
    irq(3'h1, 1'b0, 1'b0, 4'h0, 8'h60, 1'b1, VEC_SPURIOUS);
    iackFault <= 1'b0;
    resetInstr <= 1'b1;
    @(posedge ref_clk);
    resetInstr <= 1'b0;
    pulseLen = 8'h00;
    // Count from the launching edge so the first cycle of the pulse is included.
    repeat (200) begin
      #1 pulseLen += {7'h00, link.sysReset === 1'b1};
      @(posedge ref_clk);
    end
    cmpVec("sysReset length", RESET_PULSE_CYCLES, pulseLen);
    cmpVec("lastVector kept", VEC_SPURIOUS, lastVector);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    await(VEC_RESET_PC, hpc(BOOT_ROM_BASE + RESET_PC_ADDR));
    close_out();
  end
endmodule
